//--- verilog/vslc_params.svh
// constants of the video sync and luminance control register bank
// assumes a 32-bit apb with 12-bit byte addresses; included by bare name
`ifndef VSLC_PARAMS_SVH
`define VSLC_PARAMS_SVH

// register indices as printed, byte address is four times the index
`define VSLC_IDX_SYNC        8'h08
`define VSLC_IDX_LUMA        8'h09
`define VSLC_IDX_STAT        8'h0f
`define VSLC_ADDR_SYNC       12'h020
`define VSLC_ADDR_LUMA       12'h024
`define VSLC_ADDR_STAT       12'h03c

// reset values
`define VSLC_RST_SYNC        8'h98
`define VSLC_RST_LUMA        8'h00

// sync control fields
`define VSLC_SYNC_AUTO_FIELD_DETECT_BIT   7
`define VSLC_SYNC_FIELD_STANDARD_SELECT_BIT   6
`define VSLC_SYNC_FORCED_PARITY_TOGGLE_BIT   5
`define VSLC_SYNC_HTC_MSB    4
`define VSLC_SYNC_HTC_LSB    3
`define VSLC_SYNC_HORIZ_PLL_OPEN_BIT   2
`define VSLC_SYNC_VNR_MSB    1
`define VSLC_SYNC_VNR_LSB    0

// luminance control fields
`define VSLC_LUMA_TRAP_COMB_BYPASS_BIT   7
`define VSLC_LUMA_COMB_BIT   6
`define VSLC_LUMA_EXTRA_LINE_DELAY_BIT   5
`define VSLC_LUMA_REMOD_BANDWIDTH_BIT   4
`define VSLC_LUMA_SHP_MSB    3
`define VSLC_LUMA_SHP_LSB    0

// status fields
`define VSLC_STAT_F60_BIT    0
`define VSLC_STAT_ODD_BIT    1
`define VSLC_STAT_HRSV_BIT   2
`define VSLC_STAT_VCFL_BIT   3
`define VSLC_STAT_PLLO_BIT   4

// frame geometry and extra delay
`define VSLC_LINES_50HZ      10'h271
`define VSLC_LINES_60HZ      10'h20d
`define VSLC_DELAY_NTSC      2'h1
`define VSLC_DELAY_PAL       2'h2
`define VSLC_DELAY_NONE      2'h0

`endif

//--- verilog/vslc_pkg.sv
// types of the video sync and luminance control register bank
// assumes vslc_params.svh for the numeric constants
package vslc_pkg;

   typedef enum logic [1:0] {
      VSLC_HTC_TV   = 2'b00,
      VSLC_HTC_VTR  = 2'b01,
      VSLC_HTC_RSVD = 2'b10,
      VSLC_HTC_FAST = 2'b11
   } vslc_htc_t;

   typedef enum logic [1:0] {
      VSLC_VNR_NORMAL = 2'b00,
      VSLC_VNR_FAST   = 2'b01,
      VSLC_VNR_FREE   = 2'b10,
      VSLC_VNR_BYPASS = 2'b11
   } vslc_vnr_t;

   typedef enum logic [1:0] {
      VSLC_YF_TRAP   = 2'b00,
      VSLC_YF_COMB   = 2'b01,
      VSLC_YF_BYPASS = 2'b10
   } vslc_yfilt_t;

   typedef enum logic [1:0] {
      VSLC_SHP_PLAIN   = 2'b00,
      VSLC_SHP_PEAK    = 2'b01,
      VSLC_SHP_LOWPASS = 2'b10
   } vslc_sharp_t;

endpackage : vslc_pkg

//--- verilog/vslc_field_ctl.sv
// field standard choice and odd/even parity generation
// assumes field_start, detected_60hz and source_interlaced come from pclk logic
`timescale 1ns/1ps
module vslc_field_ctl (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control fields
   input  wire logic auto_field_detect,
   input  wire logic field_standard_select,
   input  wire logic forced_parity_toggle,
   // datapath status
   input  wire logic detected_60hz,
   input  wire logic source_interlaced,
   input  wire logic field_start,
   // results
   output logic      field_60hz_ff,
   output logic      odd_even_ff
);

   logic nxt_field_60hz;
   logic toggle_ok;
   logic nxt_odd_even;

   // auto detection follows the datapath, else the select bit forces it
   assign nxt_field_60hz = auto_field_detect ? detected_60hz : // [RULE2]
                           field_standard_select;              // [RULE1]

   // a progressive source keeps a fixed parity unless toggling is forced
   assign toggle_ok    = source_interlaced | forced_parity_toggle; // [RULE3]
   assign nxt_odd_even = (field_start & toggle_ok) ? ~odd_even_ff : odd_even_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         field_60hz_ff <= 1'b0;
         odd_even_ff   <= 1'b0;
      end else begin
         field_60hz_ff <= nxt_field_60hz;
         odd_even_ff   <= nxt_odd_even;
      end
   end

endmodule : vslc_field_ctl

//--- verilog/vslc_regs.sv
// apb register bank for video sync and luminance processing control
// assumes an apb master on pclk and datapath status inputs on the same clock
//
// Functional notes
// [RULE1] with auto detect off, select bit picks 50 Hz/625 or 60 Hz/525
// [RULE2] with auto detect on, field standard follows the detected standard
// [RULE3] parity toggles only for interlaced source unless forced every field
// [RULE4] horizontal time constant codes: 00 tv, 01 vtr, 11 fast, 10 reserved
// [RULE5] pll bit 0 keeps horizontal pll closed, 1 opens it at fixed frequency
// [RULE6] vertical noise codes: 00 normal, 10 free running, 11 bypassed
// [RULE7] software uses vertical fast mode only with auto detect disabled
// [RULE8] bypass bit 0 keeps trap or comb active, 1 bypasses it
// [RULE9] without bypass, comb enable picks trap at 0, adaptive comb at 1
// [RULE10] outside comb mode, delay bit adds one ntsc or two pal lines
// [RULE11] bandwidth bit 0 narrow notch, 1 wider notch lower luma bandwidth
// [RULE12] sharpness 0000 plain, 0001 to 0111 peaking from 8.0 to 1.6 dB
// [RULE13] sharpness 1000 to 1111 low-pass filters of decreasing bandwidth
// [RULE14] software picks vtr time constant with direct deflection control
// [RULE15] both registers are 8-bit read/write, fields apply next cycle
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "vslc_params.svh"
module vslc_regs
   import vslc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata_ff,
   output logic                   pready_ff,
   output logic                   pslverr_ff,
   // datapath status
   input  wire logic              detected_60hz,
   input  wire logic              source_interlaced,
   input  wire logic              field_start,
   input  wire logic              color_is_pal,
   // sync controls
   output logic                   field_60hz_ff,
   output logic      [9:0]        lines_per_frame_ff,
   output logic                   odd_even_ff,
   output vslc_htc_t              horiz_time_constant_ff,
   output logic                   horiz_pll_open_ff,
   output vslc_vnr_t              vert_noise_mode_ff,
   // luminance controls
   output vslc_yfilt_t            luma_filter_mode_ff,
   output logic      [1:0]        extra_delay_lines_ff,
   output logic                   remod_bandwidth_ff,
   output vslc_sharp_t            sharp_class_ff,
   output logic      [2:0]        sharp_step_ff,
   output logic      [7:0]        sharp_peak_db10_ff
);

   localparam int NREG = 2;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic              setup_ph;
   logic              access_ph;
   logic              hit_sync;
   logic              hit_luma;
   logic              hit_stat;
   logic              hit_any;
   logic              bad_req;
   logic              wr_commit;
   logic [NREG-1:0]   reg_sel;
   logic [7:0]        ctrl_ff [NREG];
   logic [7:0]        stat_word;
   logic [31:0]       rd_word;
   logic [31:0]       nxt_prdata;
   logic              nxt_pready;
   logic              nxt_pslverr;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable & pready_ff;
   assign hit_sync  = (paddr == `VSLC_ADDR_SYNC);
   assign hit_luma  = (paddr == `VSLC_ADDR_LUMA);
   assign hit_stat  = (paddr == `VSLC_ADDR_STAT);
   assign hit_any   = hit_sync | hit_luma | hit_stat;
   // status is read-only, so a write there is answered as an error
   assign bad_req   = ~hit_any | (pwrite & hit_stat);
   // commit happens only at the access edge that sees pready high
   assign wr_commit = access_ph & pwrite & ~pslverr_ff & pstrb[0];
   assign reg_sel   = {hit_luma, hit_sync};

   // one wait-free access phase: pready rises the cycle after setup
   assign nxt_pready  = setup_ph;
   assign nxt_pslverr = setup_ph & bad_req;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // ---------------------------------------------------------------
   // control storage, one word per register
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_ctrl
         logic [7:0] rst_val;
         logic [7:0] nxt_ctrl;
         assign rst_val  = (gi == 0) ? `VSLC_RST_SYNC : `VSLC_RST_LUMA;
         assign nxt_ctrl = (wr_commit & reg_sel[gi]) ? pwdata[7:0] : // [RULE15]
                           ctrl_ff[gi];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_ff[gi] <= rst_val;
            end else begin
               ctrl_ff[gi] <= nxt_ctrl;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // field extraction
   // ---------------------------------------------------------------
   logic       auto_field_detect;
   logic       field_standard_select;
   logic       forced_parity_toggle;
   logic [1:0] horiz_time_constant;
   logic       horiz_pll_open;
   logic [1:0] vert_noise_mode;
   logic       trap_comb_bypass;
   logic       adaptive_comb_enable;
   logic       extra_line_delay;
   logic       remod_bandwidth;
   logic [3:0] sharpness_filter_sel;

   assign auto_field_detect     = ctrl_ff[0][`VSLC_SYNC_AUTO_FIELD_DETECT_BIT];
   assign field_standard_select = ctrl_ff[0][`VSLC_SYNC_FIELD_STANDARD_SELECT_BIT];
   assign forced_parity_toggle  = ctrl_ff[0][`VSLC_SYNC_FORCED_PARITY_TOGGLE_BIT];
   assign horiz_time_constant   = ctrl_ff[0][`VSLC_SYNC_HTC_MSB:`VSLC_SYNC_HTC_LSB];
   assign horiz_pll_open        = ctrl_ff[0][`VSLC_SYNC_HORIZ_PLL_OPEN_BIT];
   assign vert_noise_mode       = ctrl_ff[0][`VSLC_SYNC_VNR_MSB:`VSLC_SYNC_VNR_LSB];
   assign trap_comb_bypass      = ctrl_ff[1][`VSLC_LUMA_TRAP_COMB_BYPASS_BIT];
   assign adaptive_comb_enable  = ctrl_ff[1][`VSLC_LUMA_COMB_BIT];
   assign extra_line_delay      = ctrl_ff[1][`VSLC_LUMA_EXTRA_LINE_DELAY_BIT];
   assign remod_bandwidth       = ctrl_ff[1][`VSLC_LUMA_REMOD_BANDWIDTH_BIT];
   assign sharpness_filter_sel  = ctrl_ff[1][`VSLC_LUMA_SHP_MSB:`VSLC_LUMA_SHP_LSB];

   // ---------------------------------------------------------------
   // sync path
   // ---------------------------------------------------------------
   vslc_field_ctl u_field_ctl (
      .pclk                  (pclk),
      .presetn               (presetn),
      .auto_field_detect     (auto_field_detect),
      .field_standard_select (field_standard_select),
      .forced_parity_toggle  (forced_parity_toggle),
      .detected_60hz         (detected_60hz),
      .source_interlaced     (source_interlaced),
      .field_start           (field_start),
      .field_60hz_ff         (field_60hz_ff),
      .odd_even_ff           (odd_even_ff)
   );

   logic [9:0] nxt_lines;
   vslc_htc_t  nxt_htc;
   vslc_vnr_t  nxt_vnr;
   logic       htc_reserved;
   logic       vnr_fast_conflict;

   assign nxt_lines = field_60hz_ff ? `VSLC_LINES_60HZ : `VSLC_LINES_50HZ; // [RULE1]
   // the reserved code is passed on as is, the datapath must not act on it
   assign nxt_htc      = vslc_htc_t'(horiz_time_constant); // [RULE4]
   assign htc_reserved = (nxt_htc == VSLC_HTC_RSVD); // [RULE4]
   assign nxt_vnr      = vslc_vnr_t'(vert_noise_mode); // [RULE6]
   // fast mode with auto detect on is a software misuse, only flagged
   assign vnr_fast_conflict = (nxt_vnr == VSLC_VNR_FAST) & auto_field_detect; // [RULE7]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lines_per_frame_ff     <= `VSLC_LINES_50HZ;
         horiz_time_constant_ff <= VSLC_HTC_FAST;
         horiz_pll_open_ff      <= 1'b0;
         vert_noise_mode_ff     <= VSLC_VNR_NORMAL;
      end else begin
         lines_per_frame_ff     <= nxt_lines;
         horiz_time_constant_ff <= nxt_htc;
         horiz_pll_open_ff      <= horiz_pll_open; // [RULE5]
         vert_noise_mode_ff     <= nxt_vnr;
      end
   end

   // ---------------------------------------------------------------
   // luminance path
   // ---------------------------------------------------------------
   vslc_yfilt_t nxt_yfilt;
   logic        comb_active;
   logic [1:0]  nxt_delay;
   vslc_sharp_t nxt_class;
   logic [2:0]  nxt_step;
   logic [7:0]  nxt_peak;

   assign comb_active = ~trap_comb_bypass & adaptive_comb_enable; // [RULE9]
   assign nxt_yfilt = trap_comb_bypass ? VSLC_YF_BYPASS : // [RULE8]
                      (adaptive_comb_enable ? VSLC_YF_COMB : VSLC_YF_TRAP); // [RULE9]
   // the comb already carries its own line memory, so no extra delay there
   assign nxt_delay = (extra_line_delay & ~comb_active) ? // [RULE10]
                      (color_is_pal ? `VSLC_DELAY_PAL : `VSLC_DELAY_NTSC) :
                      `VSLC_DELAY_NONE;

   // top bit splits peaking from low-pass, zero alone is the plain response
   assign nxt_class = sharpness_filter_sel[3] ? VSLC_SHP_LOWPASS : // [RULE13]
                      ((sharpness_filter_sel == 4'h0) ? VSLC_SHP_PLAIN : // [RULE12]
                       VSLC_SHP_PEAK);
   // peaking steps count from 0 at the strongest, low-pass from the widest
   assign nxt_step = sharpness_filter_sel[3] ? sharpness_filter_sel[2:0] : // [RULE13]
                     ((sharpness_filter_sel == 4'h0) ? 3'h0 :
                      (sharpness_filter_sel[2:0] - 3'h1)); // [RULE12]

   // peaking gain at 4.1 MHz in tenths of a dB, zero outside peaking
   always_comb begin
      case (sharpness_filter_sel) // [RULE12]
         4'h1:    nxt_peak = 8'h50;
         4'h2:    nxt_peak = 8'h44;
         4'h3:    nxt_peak = 8'h33;
         4'h4:    nxt_peak = 8'h29;
         4'h5:    nxt_peak = 8'h1e;
         4'h6:    nxt_peak = 8'h17;
         4'h7:    nxt_peak = 8'h10;
         default: nxt_peak = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         luma_filter_mode_ff  <= VSLC_YF_TRAP;
         extra_delay_lines_ff <= `VSLC_DELAY_NONE;
         remod_bandwidth_ff   <= 1'b0;
         sharp_class_ff       <= VSLC_SHP_PLAIN;
         sharp_step_ff        <= 3'h0;
         sharp_peak_db10_ff   <= 8'h00;
      end else begin
         luma_filter_mode_ff  <= nxt_yfilt;
         extra_delay_lines_ff <= nxt_delay;
         remod_bandwidth_ff   <= remod_bandwidth; // [RULE11]
         sharp_class_ff       <= nxt_class;
         sharp_step_ff        <= nxt_step;
         sharp_peak_db10_ff   <= nxt_peak;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb begin
      stat_word                      = 8'h00;
      stat_word[`VSLC_STAT_F60_BIT]  = field_60hz_ff;
      stat_word[`VSLC_STAT_ODD_BIT]  = odd_even_ff;
      stat_word[`VSLC_STAT_HRSV_BIT] = htc_reserved;
      stat_word[`VSLC_STAT_VCFL_BIT] = vnr_fast_conflict;
      stat_word[`VSLC_STAT_PLLO_BIT] = horiz_pll_open_ff;
   end

   // read data is latched in setup so it stands through the access phase
   assign rd_word = hit_sync ? {24'h000000, ctrl_ff[0]} : // [RULE15]
                    hit_luma ? {24'h000000, ctrl_ff[1]} :
                    hit_stat ? {24'h000000, stat_word} : 32'h00000000;
   assign nxt_prdata = (setup_ph & ~pwrite) ? rd_word :
                       (access_ph ? 32'h00000000 : prdata_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

endmodule : vslc_regs

//--- sim/vslc_regs_chk.sv
// concurrent checks on the ports of the sync and luminance control register bank
// assumes a single pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/1ps
module vslc_regs_chk
   import vslc_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata_ff,
   input wire logic        pready_ff,
   input wire logic        pslverr_ff,
   // datapath and controls
   input wire logic        source_interlaced,
   input wire logic        field_start,
   input wire logic        field_60hz_ff,
   input wire logic [9:0]  lines_per_frame_ff,
   input wire logic        odd_even_ff,
   input wire vslc_htc_t   horiz_time_constant_ff,
   input wire vslc_yfilt_t luma_filter_mode_ff,
   input wire logic [1:0]  extra_delay_lines_ff,
   input wire vslc_sharp_t sharp_class_ff,
   input wire logic [2:0]  sharp_step_ff,
   input wire logic [7:0]  sharp_peak_db10_ff
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready_ff)
      else $error("no ready after setup");
   AST_PREADY_CAUSE: assert property (pready_ff |-> $past(psel && !penable))
      else $error("ready without setup");
   AST_ERR_ANSWER: assert property (pslverr_ff |-> pready_ff && prdata_ff == 32'h0)
      else $error("error answer malformed");
   AST_RDATA_UPPER: assert property (pready_ff |-> prdata_ff[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_RDATA_IDLE: assert property (!pready_ff |-> prdata_ff == 32'h0)
      else $error("read data outside access");
   AST_LINES: assert property (lines_per_frame_ff == ($past(field_60hz_ff) ? 10'h20d : 10'h271))
      else $error("line count wrong for standard");
   AST_TOGGLE: assert property (field_start && source_interlaced |=> odd_even_ff != $past(odd_even_ff))
      else $error("parity did not toggle");
   AST_PARITY_CAUSE: assert property ($changed(odd_even_ff) |-> $past(field_start))
      else $error("parity changed without field start");
   // the time constant output may only move one or two edges after a committed write
   AST_HTC_ON_WRITE: assert property ($changed(horiz_time_constant_ff) |-> $past(pready_ff && pwrite, 2) || $past(pready_ff && pwrite))
      else $error("time constant moved without write");
   AST_COMB_NO_DELAY: assert property (luma_filter_mode_ff == VSLC_YF_COMB |-> extra_delay_lines_ff == 2'h0)
      else $error("extra delay in comb mode");
   AST_PLAIN: assert property (sharp_class_ff == VSLC_SHP_PLAIN |-> sharp_step_ff == 3'h0 && sharp_peak_db10_ff == 8'h00)
      else $error("plain response with step");
   AST_PEAK_TOP: assert property (sharp_class_ff == VSLC_SHP_PEAK && sharp_step_ff == 3'h0 |-> sharp_peak_db10_ff == 8'h50)
      else $error("first peaking step wrong");

   COV_WRITE: cover property (psel && penable && pwrite && pready_ff);
   COV_ERR: cover property (pslverr_ff);
   COV_TOGGLE: cover property (field_start && source_interlaced);
endmodule : vslc_regs_chk

bind vslc_regs vslc_regs_chk u_vslc_regs_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .prdata_ff, .pready_ff, .pslverr_ff,
   .source_interlaced, .field_start, .field_60hz_ff, .lines_per_frame_ff, .odd_even_ff,
   .horiz_time_constant_ff, .luma_filter_mode_ff, .extra_delay_lines_ff,
   .sharp_class_ff, .sharp_step_ff, .sharp_peak_db10_ff
);

//--- sim/vslc_tb.sv
// self-checking bench for the sync and luminance control register bank
// assumes the bank answers every apb request after one access cycle
`timescale 1ns/1ps
`include "vslc_params.svh"
module tb
   import vslc_pkg::*;
;
   typedef struct {
      logic [7:0] s, l;
      logic pal, d60, f60;
      vslc_yfilt_t fm;
      logic [1:0] dl;
   } vslc_row_t;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_ff, rd;
   logic [3:0]  pstrb;
   logic        detected_60hz, source_interlaced, field_start, color_is_pal;
   logic        pready_ff, pslverr_ff, field_60hz_ff, odd_even_ff, err, e;
   logic        horiz_pll_open_ff, remod_bandwidth_ff;
   logic [9:0]  lines_per_frame_ff;
   logic [1:0]  extra_delay_lines_ff;
   logic [2:0]  sharp_step_ff;
   logic [7:0]  sharp_peak_db10_ff;
   vslc_htc_t   horiz_time_constant_ff;
   vslc_vnr_t   vert_noise_mode_ff;
   vslc_yfilt_t luma_filter_mode_ff;
   vslc_sharp_t sharp_class_ff;
   int          failures, n_checks;
   logic [7:0]  dbt [8] = '{8'h00, 8'h50, 8'h44, 8'h33, 8'h29, 8'h1e, 8'h17, 8'h10};
   vslc_row_t   rows [5] = '{
      '{8'h00, 8'h00, 1'b0, 1'b1, 1'b0, VSLC_YF_TRAP, `VSLC_DELAY_NONE},
      '{8'h40, 8'h20, 1'b0, 1'b0, 1'b1, VSLC_YF_TRAP, `VSLC_DELAY_NTSC},
      '{8'h8a, 8'h60, 1'b1, 1'b1, 1'b1, VSLC_YF_COMB, `VSLC_DELAY_NONE},
      '{8'h9f, 8'hb0, 1'b1, 1'b0, 1'b0, VSLC_YF_BYPASS, `VSLC_DELAY_PAL},
      '{8'h51, 8'h70, 1'b1, 1'b0, 1'b1, VSLC_YF_COMB, `VSLC_DELAY_NONE}};

   vslc_regs u_vslc_regs (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata_ff, .pready_ff, .pslverr_ff, .detected_60hz, .source_interlaced,
      .field_start, .color_is_pal, .field_60hz_ff, .lines_per_frame_ff, .odd_even_ff,
      .horiz_time_constant_ff, .horiz_pll_open_ff, .vert_noise_mode_ff,
      .luma_filter_mode_ff, .extra_delay_lines_ff, .remod_bandwidth_ff,
      .sharp_class_ff, .sharp_step_ff, .sharp_peak_db10_ff
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // the request is held until the edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_ff !== 1'b1 && n < 50);
      // a bus that never answers counts as a mismatch
      if (n >= 50) failures++;
      rd = prdata_ff;
      err = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'h1);
      repeat (3) @(posedge pclk);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [7:0] d);
      apb(1'b0, a, 8'h00, 4'h0);
      chk(rd, {24'h0, d});
   endtask : rdc

   task automatic pulse(input logic il);
      @(posedge pclk);
      source_interlaced <= il;
      field_start <= 1'b1;
      @(posedge pclk);
      field_start <= 1'b0;
      @(posedge pclk);
   endtask : pulse

   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      #100000;
      failures++;
      finish_test();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {detected_60hz, source_interlaced, field_start, color_is_pal} = '0;
      failures = 0;
      n_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         @(posedge pclk);
         detected_60hz <= rows[i].d60;
         color_is_pal <= rows[i].pal;
         wr(`VSLC_ADDR_SYNC, rows[i].s);
         wr(`VSLC_ADDR_LUMA, rows[i].l);
         chk(field_60hz_ff, rows[i].f60);
         chk(lines_per_frame_ff, rows[i].f60 ? 10'h20d : 10'h271);
         chk(horiz_time_constant_ff, rows[i].s[4:3]);
         chk(horiz_pll_open_ff, rows[i].s[2]);
         chk(vert_noise_mode_ff, rows[i].s[1:0]);
         chk(luma_filter_mode_ff, rows[i].fm);
         chk(extra_delay_lines_ff, rows[i].dl);
         chk(remod_bandwidth_ff, rows[i].l[4]);
         rdc(`VSLC_ADDR_SYNC, rows[i].s);
         rdc(`VSLC_ADDR_LUMA, rows[i].l);
      end
      for (int c = 0; c < 16; c++) begin
         wr(`VSLC_ADDR_LUMA, 8'(c));
         chk(sharp_class_ff, c == 0 ? VSLC_SHP_PLAIN : c < 8 ? VSLC_SHP_PEAK : VSLC_SHP_LOWPASS);
         chk(sharp_step_ff, c == 0 ? 3'h0 : c < 8 ? 3'(c - 1) : 3'(c));
         chk(sharp_peak_db10_ff, c < 8 ? dbt[c] : 8'h00);
      end
      // reset in mid-run, then reset values and the refused requests
      @(posedge pclk);
      presetn <= 1'b0;
      detected_60hz <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(horiz_time_constant_ff, VSLC_HTC_FAST);
      chk(lines_per_frame_ff, 10'h271);
      rdc(`VSLC_ADDR_SYNC, `VSLC_RST_SYNC);
      rdc(`VSLC_ADDR_LUMA, `VSLC_RST_LUMA);
      apb(1'b0, 12'h100, 8'h00, 4'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, `VSLC_ADDR_STAT, 8'hff, 4'h1);
      chk(err, 1'b1);
      apb(1'b1, `VSLC_ADDR_LUMA, 8'h5a, 4'h0);
      chk(err, 1'b0);
      rdc(`VSLC_ADDR_LUMA, `VSLC_RST_LUMA);
      // parity: held when progressive, toggles when interlaced or forced
      e = 1'b0;
      pulse(1'b0);
      chk(odd_even_ff, e);
      pulse(1'b1);
      e = ~e;
      chk(odd_even_ff, e);
      wr(`VSLC_ADDR_SYNC, 8'hb8);
      pulse(1'b0);
      e = ~e;
      chk(odd_even_ff, e);
      // status: forced 60 Hz, reserved time constant, pll open, parity bit
      wr(`VSLC_ADDR_SYNC, 8'h54);
      rdc(`VSLC_ADDR_STAT, 8'h15 | {6'h0, e, 1'b0});
      finish_test();
   end
endmodule : tb
